/* design/vcs_consts.svh */
// constants for the valve command and solenoid drive block
`ifndef VCS_CONSTS_SVH
`define VCS_CONSTS_SVH

`define VCS_CLK_HZ       50000000
`define VCS_PWM_HZ       1000
`define VCS_MS_HZ        1000
`define VCS_FULL         13'sh03e8
`define VCS_ZERO         13'sh0000
`define VCS_DITH_PER     4'h5
`define VCS_OPM_UNI1     2'h0
`define VCS_OPM_UNI2     2'h1
`define VCS_OPM_BIP      2'h2
`define VCS_OPM_DIN      2'h3
`define VCS_DOUT_FOLLOW  2'h0
`define VCS_DOUT_LOW     2'h1
`define VCS_DOUT_HIGH    2'h2
`define VCS_SRC_PIN      4'h0
`define VCS_SRC_NONE     4'hf
`define VCS_RST_ISIG     8'h00

`endif

/* design/vcs_drive.sv */
// command shaping, solenoid selection, pwm with dither and power reduction
`timescale 1ns/1ps
`default_nettype none
`include "vcs_consts.svh"

module vcs_drive
    import vcs_pkg::*;
#(
    parameter int unsigned PWM_CYC = `VCS_CLK_HZ / `VCS_PWM_HZ,
    parameter int unsigned MS_CYC  = `VCS_CLK_HZ / `VCS_MS_HZ
)
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire vcs_ch_t [1:0] ch,
    input  wire vcs_sol_t [1:0] sol,
    input  wire logic         din_pin,
    input  wire logic         dout_func,
    input  wire logic [1:0]   dout_mode,
    input  wire logic [3:0]   dout_dst,
    output var  logic [1:0]   sol_on,
    output var  logic [1:0]   meas_en,
    output var  logic         dig_out,
    output var  logic [7:0]   isig,
    output var  logic [1:0]   cfg_err
);

    if (PWM_CYC < 1000 || PWM_CYC > 65536 || MS_CYC < 1 || MS_CYC > 65536)
    begin : g_bad_param
        $error("vcs_drive: PWM_CYC or MS_CYC out of range");
    end

    vcs_state_t s;
    vcs_state_t next_s;

    // values shared by logic and checks
    logic [1:0][1:0][9:0] drv;
    logic [1:0][9:0]      eff;
    logic [1:0]           pr_ok;

    function automatic logic signed [12:0] sat(input logic signed [12:0] v,
                                               input logic signed [12:0] lo,
                                               input logic signed [12:0] hi);
        logic signed [12:0] r;
        r = v;
        if (v < lo)
        begin
            r = lo;
        end
        if (v > hi)
        begin
            r = hi;
        end
        return r;
    endfunction : sat

    function automatic logic [9:0] pos_part(input logic signed [12:0] v);
        return (v > `VCS_ZERO) ? v[9:0] : 10'h000;
    endfunction : pos_part

    function automatic logic [9:0] neg_part(input logic signed [12:0] v);
        logic signed [12:0] n;
        n = -v;
        return (v < `VCS_ZERO) ? n[9:0] : 10'h000;
    endfunction : neg_part

    always_comb
    begin
        logic               din;
        logic signed [12:0] in_v;
        logic signed [12:0] uni;
        logic signed [12:0] icmd;
        logic signed [12:0] ctl;
        logic signed [12:0] dv;
        logic [9:0]         duty;
        logic               legal;
        logic               dval;
        din    = 1'b0;
        in_v   = `VCS_ZERO;
        uni    = `VCS_ZERO;
        icmd   = `VCS_ZERO;
        ctl    = `VCS_ZERO;
        dv     = `VCS_ZERO;
        duty   = 10'h000;
        legal  = 1'b0;
        dval   = 1'b0;
        drv    = '0;
        eff    = '0;
        pr_ok  = '0;
        next_s = s;

        // pwm frame and millisecond tick
        next_s.cnt = (32'(s.cnt) == PWM_CYC - 1) ? 16'h0000 : s.cnt + 16'h0001;
        next_s.ms_tick = (32'(s.ms_cnt) == MS_CYC - 1);
        next_s.ms_cnt = next_s.ms_tick ? 16'h0000 : s.ms_cnt + 16'h0001;
        if (s.cnt == 16'h0000)
        begin
            next_s.dith_cnt = (s.dith_cnt == `VCS_DITH_PER - 4'h1) ? 4'h0
                                                                  : s.dith_cnt + 4'h1;
            if (s.dith_cnt == `VCS_DITH_PER - 4'h1)
            begin
                next_s.dith_ph = ~s.dith_ph;
            end
        end

        // pin passes two flops before use
        next_s.din_meta = din_pin;
        next_s.din_sync = s.din_meta;

        for (int c = 0; c < 2; c++)
        begin
            if (ch[c].din_src == `VCS_SRC_PIN)
            begin
                din = s.din_sync;
            end
            else if (ch[c].din_src == `VCS_SRC_NONE || ch[c].din_src > 4'h8)
            begin
                din = 1'b0;
            end
            else
            begin
                din = s.isig[3'(ch[c].din_src - 4'h1)];
            end

            in_v = 13'(ch[c].cmd);
            uni  = sat(in_v, `VCS_ZERO, `VCS_FULL);
            case (ch[c].op_mode)
                `VCS_OPM_UNI1: icmd = uni;
                `VCS_OPM_UNI2: icmd = 13'((uni <<< 1) - `VCS_FULL);
                `VCS_OPM_BIP:  icmd = sat(in_v, -`VCS_FULL, `VCS_FULL);
                `VCS_OPM_DIN:  icmd = din ? -uni : uni;
                default:       icmd = `VCS_ZERO;
            endcase
            ctl = sat(13'(ch[c].ctl), -`VCS_FULL, `VCS_FULL);

            legal = (c == 0) || ch[c].ctl_mode == CM_1 || ch[c].ctl_mode == CM_3
                    || ch[c].ctl_mode == CM_6;
            if (ch[c].op_mode == `VCS_OPM_UNI1 && !ch[c].two_sol)
            begin
                legal = 1'b0;
            end
            if (ch[c].ctl_mode > CM_N8)
            begin
                legal = 1'b0;
            end

            case (ch[c].ctl_mode)
                CM_1, CM_3, CM_6:
                begin
                    if (ch[c].op_mode == `VCS_OPM_UNI1)
                    begin
                        drv[c][0] = pos_part(icmd);
                    end
                    else
                    begin
                        drv[c][0] = pos_part(icmd);
                        drv[c][1] = neg_part(icmd);
                    end
                end
                CM_4: drv[c][0] = pos_part(ctl);
                CM_N5, CM_9, CM_7:
                begin
                    drv[c][0] = pos_part(ctl);
                    drv[c][1] = neg_part(ctl);
                end
                CM_N6: drv[c][0] = (ctl > `VCS_ZERO) ? 10'(`VCS_FULL) : 10'h000;
                CM_N7:
                begin
                    drv[c][0] = (ctl > `VCS_ZERO) ? 10'(`VCS_FULL) : 10'h000;
                    drv[c][1] = (ctl > `VCS_ZERO) ? 10'(`VCS_FULL) : 10'h000;
                end
                CM_N8:
                begin
                    drv[c][0] = (ctl > `VCS_ZERO) ? 10'(`VCS_FULL) : 10'h000;
                    drv[c][1] = (ctl < `VCS_ZERO) ? 10'(`VCS_FULL) : 10'h000;
                end
                default: drv[c] = '0;
            endcase
            if (!legal)
            begin
                drv[c] = '0;
            end
            next_s.err[c] = !legal;
        end

        for (int k = 0; k < 2; k++)
        begin
            duty = drv[sol[k].own_ch][sol[k].own_drv];
            pr_ok[k] = sol[k].pr_en && sol[k].switching && !sol[k].meas_on;
            case (s.pr[k])
                PR_OFF:
                begin
                    next_s.pr_ms[k] = 16'h0000;
                    if (duty != 10'h000)
                    begin
                        next_s.pr[k] = PR_FULL;
                    end
                end
                PR_FULL:
                begin
                    if (s.ms_tick && s.pr_ms[k] != 16'hffff)
                    begin
                        next_s.pr_ms[k] = s.pr_ms[k] + 16'h0001;
                    end
                    if (pr_ok[k] && s.pr_ms[k] >= sol[k].red_ms)
                    begin
                        next_s.pr[k] = PR_RED;
                    end
                end
                PR_RED:  next_s.pr[k] = pr_ok[k] ? PR_RED : PR_FULL;
                default: next_s.pr[k] = PR_OFF;
            endcase
            if (duty == 10'h000)
            begin
                next_s.pr[k] = PR_OFF;
            end
            eff[k] = (s.pr[k] == PR_RED && duty > sol[k].red_val) ? sol[k].red_val : duty;

            dv = 13'(eff[k]);
            if (eff[k] != 10'h000)
            begin
                dv = s.dith_ph ? dv + 13'(sol[k].dith_amp) : dv - 13'(sol[k].dith_amp);
                dv = sat(dv, `VCS_ZERO, `VCS_FULL);
            end
            // compare scaled so no divider is needed
            next_s.sol_on[k] = (32'(s.cnt) * 32'd1000) < (32'(dv[9:0]) * PWM_CYC);
            next_s.meas[k] = sol[k].meas_on;
        end

        case (dout_mode)
            `VCS_DOUT_LOW:  dval = 1'b0;
            `VCS_DOUT_HIGH: dval = 1'b1;
            default:        dval = dout_func;
        endcase
        // output may land on internal signal
        next_s.isig = `VCS_RST_ISIG;
        next_s.dig_out = 1'b0;
        if (dout_dst == `VCS_SRC_PIN)
        begin
            next_s.dig_out = dval;
        end
        else if (dout_dst <= 4'h8)
        begin
            next_s.isig[3'(dout_dst - 4'h1)] = dval;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s    <= '0;
            s.pr <= '{PR_OFF, PR_OFF};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign sol_on  = s.sol_on;
    assign meas_en = s.meas;
    assign dig_out = s.dig_out;
    assign isig    = s.isig;
    assign cfg_err = s.err;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence seq_frame_end;
        32'(s.cnt) == PWM_CYC - 1;
    endsequence

    sequence seq_frame_start;
        s.cnt == 16'h0000;
    endsequence

    chk_pwm_wrap: assert property (seq_frame_end |=> seq_frame_start)
        else $error("pwm counter did not wrap at period end");

    chk_meas_follow: assert property (##1 meas_en[0] == $past(sol[0].meas_on))
        else $error("measurement enable did not follow config");

    chk_dout_force: assert property ((dout_dst == `VCS_SRC_PIN
                                      && dout_mode == `VCS_DOUT_HIGH) |=> dig_out)
        else $error("forced high output not high");

    chk_isig_link: assert property ((dout_dst == 4'h1 && dout_mode == `VCS_DOUT_FOLLOW)
                                    |=> (isig == {7'h00, $past(dout_func)} && !dig_out))
        else $error("internal signal link wrong");

    chk_ch2_modes: assert property ((ch[1].ctl_mode == CM_4 || ch[1].ctl_mode == CM_9)
                                    |=> cfg_err[1])
        else $error("closed loop mode accepted on channel two");

    chk_one_driver: assert property ((ch[0].ctl_mode == CM_4 || ch[0].ctl_mode == CM_N6)
                                     |-> drv[0][1] == 10'h000)
        else $error("second driver used in single solenoid mode");

    chk_pr_allowed: assert property ((s.pr[0] == PR_FULL && !pr_ok[0])
                                     |=> s.pr[0] != PR_RED)
        else $error("power reduction entered while not allowed");

    chk_red_limit: assert property (s.pr[0] == PR_RED |-> eff[0] <= sol[0].red_val)
        else $error("reduced current above reduced value");

    chk_full_first: assert property ((s.pr[0] == PR_OFF ##1 s.pr[0] == PR_FULL)
                                     |-> s.pr_ms[0] == 16'h0000)
        else $error("reduction timer not restarted at switch on");

endmodule : vcs_drive

`default_nettype wire

/* design/vcs_pkg.sv */
// types for the valve command and solenoid drive block
package vcs_pkg;

    typedef enum logic [3:0] {
        CM_1  = 4'h0,
        CM_3  = 4'h1,
        CM_4  = 4'h2,
        CM_N5 = 4'h3,
        CM_6  = 4'h4,
        CM_9  = 4'h5,
        CM_7  = 4'h6,
        CM_N6 = 4'h7,
        CM_N7 = 4'h8,
        CM_N8 = 4'h9
    } vcs_ctl_mode_t;

    typedef enum logic [2:0] {
        PR_OFF  = 3'b001,
        PR_FULL = 3'b010,
        PR_RED  = 3'b100
    } vcs_pr_t;

    typedef struct packed {
        vcs_ctl_mode_t      ctl_mode;
        logic [1:0]         op_mode;
        logic               two_sol;
        logic [3:0]         din_src;
        logic signed [11:0] cmd;
        logic signed [11:0] ctl;
    } vcs_ch_t;

    typedef struct packed {
        logic       own_ch;
        logic       own_drv;
        logic       switching;
        logic       meas_on;
        logic       pr_en;
        logic [15:0] red_ms;
        logic [9:0] red_val;
        logic [9:0] dith_amp;
    } vcs_sol_t;

    typedef struct packed {
        logic [15:0]      cnt;
        logic [15:0]      ms_cnt;
        logic             ms_tick;
        logic [3:0]       dith_cnt;
        logic             dith_ph;
        logic             din_meta;
        logic             din_sync;
        logic [7:0]       isig;
        logic             dig_out;
        logic [1:0]       sol_on;
        logic [1:0]       meas;
        logic [1:0]       err;
        vcs_pr_t [1:0]    pr;
        logic [1:0][15:0] pr_ms;
    } vcs_state_t;

endpackage : vcs_pkg

/* verification/vcs_drive_tb.sv */
// self-checking bench for the valve command and solenoid drive
`timescale 1ns/1ps
`default_nettype none
`include "vcs_consts.svh"
module vcs_drive_tb import vcs_pkg::*;;
    localparam int PWM = 1000;
    logic           clk = 1'b0;
    logic           rst_n = 1'b0;
    vcs_ch_t [1:0]  ch;
    vcs_sol_t [1:0] sol;
    logic           din_pin = 1'b0;
    logic           dout_func = 1'b0;
    logic [1:0]     dout_mode = `VCS_DOUT_FOLLOW;
    logic [3:0]     dout_dst = `VCS_SRC_NONE;
    logic [1:0]     sol_on;
    logic [1:0]     meas_en;
    logic           dig_out;
    logic [7:0]     isig;
    logic [1:0]     cfg_err;
    logic           clr = 1'b1;
    logic [15:0]    on_a;
    logic [15:0]    on_b;
    int             num_errors = 0;
    int             compares = 0;
    int             cycles = 0;

    always #10 clk = ~clk;

    // short frame and ms tick keep the run brief
    vcs_drive #(.PWM_CYC(PWM), .MS_CYC(10)) u_dut (
        .clk(clk), .rst_n(rst_n), .ch(ch), .sol(sol), .din_pin(din_pin),
        .dout_func(dout_func), .dout_mode(dout_mode), .dout_dst(dout_dst),
        .sol_on(sol_on), .meas_en(meas_en), .dig_out(dig_out), .isig(isig),
        .cfg_err(cfg_err));

    vcs_sol_load u_load (.clk(clk), .sol_on(sol_on), .clr(clr), .on_a(on_a), .on_b(on_b));

    task automatic wrap_up();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    always @(posedge clk)
    begin
        cycles++;
        if (cycles >= 70000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // any whole frame window holds exactly one duty's worth of on-cycles
    task automatic measure(input string what, input logic [15:0] ea, input logic [15:0] eb);
        step(2 * PWM);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(PWM);
        chk({what, " a"}, ea, on_a);
        chk({what, " b"}, eb, on_b);
    endtask : measure

    task automatic base();
        ch = '0;
        sol = '0;
        sol[1].own_drv = 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            ch[i].op_mode = `VCS_OPM_BIP;
            ch[i].two_sol = 1'b1;
            ch[i].din_src = `VCS_SRC_NONE;
        end
    endtask : base

    task automatic t_dout();
        dout_dst = `VCS_SRC_PIN;
        dout_func = 1'b1;
        dout_mode = `VCS_DOUT_LOW;
        step(2);
        chk("dout low", 16'h0000, {15'h0000, dig_out});
        dout_func = 1'b0;
        dout_mode = `VCS_DOUT_HIGH;
        step(2);
        chk("dout high", 16'h0001, {15'h0000, dig_out});
        dout_mode = `VCS_DOUT_FOLLOW;
        step(2);
        chk("dout follow", 16'h0000, {15'h0000, dig_out});
    endtask : t_dout

    task automatic t_link();
        base();
        dout_dst = 4'h1;
        dout_func = 1'b1;
        ch[0].op_mode = `VCS_OPM_DIN;
        ch[0].din_src = 4'h1;
        ch[0].cmd = 12'h12c;
        step(2);
        chk("isig", 16'h0001, {8'h00, isig});
        chk("dout routed", 16'h0000, {15'h0000, dig_out});
        measure("link neg", 16'h0000, 16'h012c);
        dout_dst = `VCS_SRC_NONE;
        ch[0].din_src = `VCS_SRC_PIN;
        din_pin = 1'b0;
        measure("din off", 16'h012c, 16'h0000);
        din_pin = 1'b1;
        measure("din on", 16'h0000, 16'h012c);
        din_pin = 1'b0;
    endtask : t_link

    task automatic t_modes();
        base();
        for (int i = 0; i < 10; i++)
        begin
            ch[0].ctl_mode = vcs_ctl_mode_t'(4'(i));
            ch[1].ctl_mode = vcs_ctl_mode_t'(4'(i));
            step(3);
            chk("err ch1", 16'h0000, {15'h0000, cfg_err[0]});
            chk("err ch2", {15'h0000, !(i == 0 || i == 1 || i == 4)},
                {15'h0000, cfg_err[1]});
        end
        base();
        ch[0].op_mode = `VCS_OPM_UNI1;
        ch[0].two_sol = 1'b0;
        ch[0].cmd = 12'h1f4;
        step(3);
        chk("err uni1", 16'h0001, {15'h0000, cfg_err[0]});
        measure("uni1 refused", 16'h0000, 16'h0000);
        ch[0].two_sol = 1'b1;
        measure("uni1", 16'h01f4, 16'h0000);
    endtask : t_modes

    task automatic t_open();
        base();
        ch[0].cmd = 12'h1f4;
        measure("bip pos", 16'h01f4, 16'h0000);
        ch[0].cmd = 12'he0c;
        measure("bip neg", 16'h0000, 16'h01f4);
        ch[0].op_mode = `VCS_OPM_UNI2;
        ch[0].cmd = 12'h2ee;
        measure("uni2 hi", 16'h01f4, 16'h0000);
        ch[0].cmd = 12'h0fa;
        measure("uni2 lo", 16'h0000, 16'h01f4);
        // second channel keeps its own mapping
        ch[0].op_mode = `VCS_OPM_BIP;
        ch[0].cmd = 12'h1f4;
        ch[1].op_mode = `VCS_OPM_UNI2;
        ch[1].cmd = 12'h2ee;
        sol[1].own_ch = 1'b1;
        sol[1].own_drv = 1'b0;
        measure("per channel", 16'h01f4, 16'h01f4);
    endtask : t_open

    task automatic t_closed();
        base();
        ch[0].op_mode = `VCS_OPM_UNI2;
        ch[0].cmd = 12'h000;
        ch[0].ctl_mode = CM_4;
        ch[0].ctl = 12'h190;
        measure("mode 4", 16'h0190, 16'h0000);
        ch[0].ctl_mode = CM_N5;
        ch[0].ctl = 12'hed4;
        measure("mode -5", 16'h0000, 16'h012c);
        ch[0].ctl_mode = CM_N7;
        ch[0].ctl = 12'h001;
        measure("mode -7", 16'h03e8, 16'h03e8);
        ch[0].ctl_mode = CM_N6;
        measure("mode -6", 16'h03e8, 16'h0000);
        ch[0].ctl_mode = CM_N8;
        ch[0].ctl = 12'hfff;
        measure("mode -8", 16'h0000, 16'h03e8);
    endtask : t_closed

    task automatic t_reduce();
        base();
        sol[0].switching = 1'b1;
        sol[0].pr_en = 1'b1;
        sol[0].red_ms = 16'h0002;
        sol[0].red_val = 10'h0c8;
        step(3);
        ch[0].cmd = 12'h3e8;
        measure("reduced", 16'h00c8, 16'h0000);
        sol[0].meas_on = 1'b1;
        step(2);
        chk("meas en", 16'h0001, {14'h0000, meas_en});
        measure("no reduce", 16'h03e8, 16'h0000);
    endtask : t_reduce

    initial
    begin
        base();
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_dout();
        t_link();
        t_modes();
        t_open();
        t_closed();
        t_reduce();
        wrap_up();
    end
endmodule : vcs_drive_tb
`default_nettype wire

/* verification/vcs_sol_load.sv */
// solenoid load model counting energised clock cycles
`timescale 1ns/1ps
`default_nettype none
module vcs_sol_load (
    input  wire logic        clk,
    input  wire logic [1:0]  sol_on,
    input  wire logic        clr,
    output var  logic [15:0] on_a,
    output var  logic [15:0] on_b
);
    // coil current tracks the gate, so on-time stands in for mean current
    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            on_a <= 16'h0000;
            on_b <= 16'h0000;
        end
        else
        begin
            on_a <= on_a + {15'h0000, sol_on[0]};
            on_b <= on_b + {15'h0000, sol_on[1]};
        end
    end
endmodule : vcs_sol_load
`default_nettype wire
